//--- asc_pkg.sv
package asc_pkg;

    // register map, one byte each
    localparam logic [2:0] CTRL_ONE_ADDR   = 3'h0;
    localparam logic [2:0] CTRL_TWO_ADDR   = 3'h1;
    localparam logic [2:0] CTRL_THREE_ADDR = 3'h2;
    localparam logic [2:0] STAT_ONE_ADDR   = 3'h3;
    localparam logic [2:0] DATA_BUF_ADDR   = 3'h4;

    // ctrl_one fields
    localparam int UNIT_ON_BIT   = 6;
    localparam int TX_FLIP_BIT   = 5;
    localparam int NINE_BIT      = 4;
    localparam int WAKE_BIT      = 3;
    localparam int IDLE_CNT_BIT  = 2;
    localparam int PARITY_ON_BIT = 1;
    localparam int PARITY_ODD_BIT = 0;

    // ctrl_two fields
    localparam int TX_EMPTY_IE_BIT = 7;
    localparam int TX_DONE_IE_BIT  = 6;
    localparam int RX_FULL_IE_BIT  = 5;
    localparam int IDLE_IE_BIT     = 4;
    localparam int TX_ON_BIT       = 3;
    localparam int RX_ON_BIT       = 2;
    localparam int STANDBY_BIT     = 1;
    localparam int BREAK_BIT       = 0;

    // ctrl_three fields
    localparam int RX_NINTH_BIT = 7;
    localparam int TX_NINTH_BIT = 6;

    localparam logic [7:0] CTRL_RESET = 8'h00;

    // frame lengths in bit times, oversampling
    localparam logic [3:0] FRAME_SHORT = 4'hA;
    localparam logic [3:0] FRAME_LONG  = 4'hB;
    localparam logic [3:0] OS_LAST     = 4'hF;
    localparam logic [3:0] SAMPLE_A    = 4'h7;
    localparam logic [3:0] SAMPLE_C    = 4'h9;

    typedef struct packed {
        logic unit_on;
        logic tx_polarity_flip;
        logic nine_bit;
        logic wake_addr;
        logic idle_count_start;
        logic parity_on;
        logic parity_odd;
    } asc_cfg_type;

    typedef struct packed {
        logic [8:0] data;
        logic       noise_flag;
        logic       framing_bad;
        logic       parity_bad;
    } asc_rx_word_type;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } asc_rx_state_type;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } asc_tx_state_type;

endpackage

//--- asc_baud.sv
module asc_baud import asc_pkg::*; #(
    parameter int BAUD_DIV = 4
) (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic run_i,
    output logic      os_tick_o,
    output logic      bit_tick_o
);
    logic [15:0] div_cnt;
    logic [3:0]  os_cnt;

    always_ff @(posedge clock_i) begin
        if (reset_i || !run_i) begin
            div_cnt   <= 16'h0000;
            os_cnt    <= 4'h0;
            os_tick_o <= 1'b0;
            bit_tick_o <= 1'b0;
        end else begin
            os_tick_o  <= 1'b0;
            bit_tick_o <= 1'b0;
            if (div_cnt == 16'(BAUD_DIV - 1)) begin
                div_cnt   <= 16'h0000;
                os_tick_o <= 1'b1;
                os_cnt    <= os_cnt + 4'h1;
                bit_tick_o <= (os_cnt == OS_LAST);
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end
endmodule // asc_baud

//--- asc_rx.sv
module asc_rx import asc_pkg::*; (
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire logic         os_tick_i,
    input  wire logic         rxd_i,
    input  wire asc_cfg_type  cfg_i,
    output logic              done_o,
    output asc_rx_word_type   word_o,
    output logic              idle_o
);
    asc_rx_state_type state;
    logic [3:0] os_cnt;
    logic [3:0] bit_cnt;
    logic [3:0] ones;
    logic [2:0] smp;
    logic [8:0] bits;
    logic       noisy;
    logic       bit_val;
    logic       bit_end;
    logic       count_on;
    logic [3:0] idle_len;
    logic [3:0] data_last;

    assign bit_val   = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
    assign bit_end   = os_tick_i && (os_cnt == OS_LAST);
    assign idle_len  = cfg_i.nine_bit ? FRAME_LONG : FRAME_SHORT;
    assign data_last = cfg_i.nine_bit ? 4'h8 : 4'h7;
    // count from start bit (any state) or only once the stop bit is over
    assign count_on  = !cfg_i.idle_count_start || (state == RX_IDLE);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state  <= RX_IDLE;
            os_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            smp    <= 3'h7;
            bits   <= 9'h000;
            noisy  <= 1'b0;
            done_o <= 1'b0;
            word_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (os_tick_i) begin
                os_cnt <= os_cnt + 4'h1;
                if (os_cnt >= SAMPLE_A && os_cnt <= SAMPLE_C)
                    smp <= {smp[1:0], rxd_i};
                if (state == RX_IDLE && !rxd_i && os_cnt != OS_LAST) begin
                    state  <= RX_START;
                    os_cnt <= 4'h0;
                    noisy  <= 1'b0;
                end
            end
            if (bit_end && state != RX_IDLE) begin
                noisy <= noisy | (smp != 3'h0 && smp != 3'h7);
                case (state)
                    RX_START: begin
                        state   <= bit_val ? RX_IDLE : RX_DATA;
                        bit_cnt <= 4'h0;
                    end
                    RX_DATA: begin
                        bits[bit_cnt] <= bit_val;
                        if (!cfg_i.nine_bit)
                            bits[8] <= 1'b0;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == data_last)
                            state <= RX_STOP;
                    end
                    default: begin
                        state              <= RX_IDLE;
                        done_o             <= 1'b1;
                        word_o.data        <= bits;
                        word_o.noise_flag  <= noisy | (smp != 3'h0 && smp != 3'h7);
                        word_o.framing_bad <= !bit_val;
                        word_o.parity_bad  <= cfg_i.parity_on
                                              && ((^bits) != cfg_i.parity_odd);
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ones   <= 4'h0;
            idle_o <= 1'b0;
        end else begin
            idle_o <= 1'b0;
            if (bit_end) begin
                if (!bit_val || (cfg_i.idle_count_start && state == RX_STOP)) begin
                    ones <= 4'h0;
                end else if (count_on && ones != idle_len) begin
                    ones   <= ones + 4'h1;
                    idle_o <= (ones == idle_len - 4'h1);
                end
            end
        end
    end
endmodule // asc_rx

//--- asc_top.sv
// Local design decisions: the address map and the plain strobed port.
module asc_top import asc_pkg::*; #(
    parameter int BAUD_DIV = 4
) (
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       write_i,
    input  wire logic       read_i,
    output logic      [7:0] rdata_o,
    input  wire logic       rxd_i,
    output logic            txd_o,
    output logic            tx_irq_o,
    output logic            rx_irq_o,
    output logic            err_irq_o
);
    asc_cfg_type      cfg;
    asc_rx_word_type  rx_word;
    asc_tx_state_type tx_state;

    logic       tx_empty_irq_en;
    logic       tx_done_irq_en;
    logic       rx_full_irq_en;
    logic       idle_irq_en;
    logic       tx_on;
    logic       rx_on;
    logic       rx_standby;
    logic       break_send;
    logic       rx_ninth;
    logic       tx_ninth;
    logic [3:0] err_irq_en;
    logic [7:0] tx_data;
    logic [7:0] data_buffer;

    logic tx_buf_empty;
    logic tx_done;
    logic rx_buf_full;
    logic idle_flag;
    logic overrun;
    logic noise_flag;
    logic framing_bad;
    logic parity_bad;
    logic idle_armed;
    logic [5:0] flags_seen;

    logic os_tick;
    logic bit_tick;
    logic rx_done;
    logic rx_idle;

    logic        tx_on_q;
    logic        pre_pend;
    logic        brk_tail;
    logic        brk_req;
    logic        brk_go;
    logic        tx_line;
    logic [10:0] frame;
    logic [3:0]  bit_cnt;
    logic [3:0]  last_bit;
    logic [3:0]  char_len;
    logic [8:0]  tx_word;
    logic        tx_par;
    logic        tx_go;
    logic        load_data;
    logic        rx_msb;
    logic        wake_addr_hit;
    logic        take_char;
    logic        wr_stat;
    logic        rd_data_clear;
    logic [7:0]  stat_one;

    asc_baud #(
        .BAUD_DIV (BAUD_DIV)
    ) u_baud (
        .clock_i    (clock_i),
        .reset_i    (reset_i),
        .run_i      (cfg.unit_on),
        .os_tick_o  (os_tick),
        .bit_tick_o (bit_tick)
    );

    // receiver restarts when disabled, flags live here untouched
    asc_rx u_rx (
        .clock_i   (clock_i),
        .reset_i   (reset_i || !rx_on || !cfg.unit_on),
        .os_tick_i (os_tick),
        .rxd_i     (rxd_i),
        .cfg_i     (cfg),
        .done_o    (rx_done),
        .word_o    (rx_word),
        .idle_o    (rx_idle)
    );

    assign stat_one = {tx_buf_empty, tx_done, rx_buf_full, idle_flag,
                       overrun, noise_flag, framing_bad, parity_bad};

    // register writes
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg <= '0;
        end else if (write_i && addr_i == CTRL_ONE_ADDR) begin
            cfg.unit_on          <= wdata_i[UNIT_ON_BIT];
            cfg.tx_polarity_flip <= wdata_i[TX_FLIP_BIT];
            cfg.nine_bit         <= wdata_i[NINE_BIT];
            cfg.wake_addr        <= wdata_i[WAKE_BIT];
            cfg.idle_count_start <= wdata_i[IDLE_CNT_BIT];
            cfg.parity_on        <= wdata_i[PARITY_ON_BIT];
            cfg.parity_odd       <= wdata_i[PARITY_ODD_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en} <= 4'h0;
            {tx_on, rx_on, break_send} <= 3'h0;
        end else if (write_i && addr_i == CTRL_TWO_ADDR) begin
            tx_empty_irq_en <= wdata_i[TX_EMPTY_IE_BIT];
            tx_done_irq_en  <= wdata_i[TX_DONE_IE_BIT];
            rx_full_irq_en  <= wdata_i[RX_FULL_IE_BIT];
            idle_irq_en     <= wdata_i[IDLE_IE_BIT];
            break_send      <= wdata_i[BREAK_BIT];
            // tx_on and rx_on only move while the unit is on
            if (cfg.unit_on) begin
                tx_on <= wdata_i[TX_ON_BIT];
                rx_on <= wdata_i[RX_ON_BIT];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_ninth   <= 1'b0;
            err_irq_en <= 4'h0;
        end else if (write_i && addr_i == CTRL_THREE_ADDR) begin
            tx_ninth   <= wdata_i[TX_NINTH_BIT];
            err_irq_en <= wdata_i[3:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i)
            tx_data <= 8'h00;
        else if (write_i && addr_i == DATA_BUF_ADDR)
            tx_data <= wdata_i;
    end

    // read data in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (read_i) begin
            if (addr_i == CTRL_ONE_ADDR)
                rdata_o <= {1'b0, cfg};
            else if (addr_i == CTRL_TWO_ADDR)
                rdata_o <= {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en,
                            tx_on, rx_on, rx_standby, break_send};
            else if (addr_i == CTRL_THREE_ADDR)
                rdata_o <= {rx_ninth, tx_ninth, 2'b00, err_irq_en};
            else if (addr_i == STAT_ONE_ADDR)
                rdata_o <= stat_one;
            else if (addr_i == DATA_BUF_ADDR)
                rdata_o <= data_buffer;
            else
                rdata_o <= 8'h00;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // receive side
    assign rx_msb        = cfg.nine_bit ? rx_word.data[8] : rx_word.data[7];
    assign wake_addr_hit = rx_done && rx_standby && cfg.wake_addr && rx_msb;
    assign take_char     = rx_done && (!rx_standby || wake_addr_hit);
    assign wr_stat       = write_i && addr_i == CTRL_TWO_ADDR;
    // clearing needs a status read first, then a data read
    assign rd_data_clear = read_i && addr_i == DATA_BUF_ADDR;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rx_standby <= 1'b0;
        end else if (wake_addr_hit || (rx_idle && rx_standby && !cfg.wake_addr)) begin
            rx_standby <= 1'b0;
        end else if (wr_stat) begin
            rx_standby <= wdata_i[STANDBY_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_buffer <= 8'h00;
            rx_ninth    <= 1'b0;
        end else if (take_char && !rx_buf_full) begin
            data_buffer <= rx_word.data[7:0];
            rx_ninth    <= rx_msb;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i)
            flags_seen <= 6'h00;
        else if (read_i && addr_i == STAT_ONE_ADDR)
            flags_seen <= stat_one[5:0];
        else if (rd_data_clear)
            flags_seen <= 6'h00;
    end

    // set wins over the clearing read
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            {rx_buf_full, idle_flag, overrun, noise_flag, framing_bad, parity_bad} <= 6'h00;
            idle_armed <= 1'b0;
        end else begin
            if (rd_data_clear)
                {rx_buf_full, idle_flag, overrun, noise_flag, framing_bad, parity_bad}
                    <= stat_one[5:0] & ~flags_seen;
            if (rd_data_clear && flags_seen[4])
                idle_armed <= 1'b0;
            if (take_char) begin
                if (rx_buf_full && !(rd_data_clear && flags_seen[5])) begin
                    overrun <= 1'b1;
                end else begin
                    rx_buf_full <= 1'b1;
                    idle_armed  <= 1'b1;
                    noise_flag  <= rx_word.noise_flag | (noise_flag & ~rd_data_clear);
                    framing_bad <= rx_word.framing_bad | (framing_bad & ~rd_data_clear);
                    parity_bad  <= rx_word.parity_bad | (parity_bad & ~rd_data_clear);
                end
            end
            // a waking idle character leaves both flags alone
            if (rx_idle && !rx_standby && idle_armed)
                idle_flag <= 1'b1;
        end
    end

    // transmit side
    assign char_len = cfg.nine_bit ? FRAME_LONG : FRAME_SHORT;
    assign tx_word  = cfg.nine_bit ? {tx_ninth, tx_data} : {1'b1, tx_data};
    assign tx_par   = (cfg.nine_bit ? ^tx_data : ^tx_data[6:0]) ^ cfg.parity_odd;
    assign tx_go    = bit_tick && (tx_state == TX_IDLE || bit_cnt == last_bit);
    assign brk_go    = break_send || brk_req;
    assign load_data = tx_go && tx_on && !brk_go && !brk_tail && !pre_pend
                       && !tx_buf_empty;

    // a short break toggle is held until the next frame slot takes it
    always_ff @(posedge clock_i) begin
        if (reset_i || !cfg.unit_on)
            brk_req <= 1'b0;
        else if (tx_go && tx_on)
            brk_req <= 1'b0;
        else if (break_send)
            brk_req <= 1'b1;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || !cfg.unit_on) begin
            tx_on_q  <= 1'b0;
            pre_pend <= 1'b0;
        end else begin
            tx_on_q <= tx_on;
            if (tx_on && !tx_on_q)
                pre_pend <= 1'b1;
            else if (tx_go && tx_on && (brk_go || !brk_tail))
                pre_pend <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || !cfg.unit_on) begin
            tx_state <= TX_IDLE;
            tx_line  <= 1'b1;
            frame    <= 11'h7FF;
            bit_cnt  <= 4'h0;
            last_bit <= 4'h0;
            brk_tail <= 1'b0;
        end else if (bit_tick) begin
            if (!tx_go) begin
                tx_line <= frame[0];
                frame   <= {1'b1, frame[10:1]};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (!tx_on) begin
                tx_state <= TX_IDLE;
                tx_line  <= 1'b1;
            end else begin
                tx_state <= TX_SHIFT;
                bit_cnt  <= 4'h0;
                last_bit <= char_len - 4'h1;
                if (brk_go) begin
                    tx_line  <= 1'b0;
                    frame    <= 11'h000;
                    brk_tail <= 1'b1;
                end else if (brk_tail) begin
                    tx_line  <= 1'b1;
                    last_bit <= 4'h0;
                    brk_tail <= 1'b0;
                end else if (pre_pend) begin
                    tx_line <= 1'b1;
                    frame   <= 11'h7FF;
                end else if (!tx_buf_empty) begin
                    tx_line <= 1'b0;
                    if (!cfg.parity_on)
                        frame <= {1'b1, 1'b1, tx_word};
                    else if (cfg.nine_bit)
                        frame <= {1'b1, 1'b1, tx_par, tx_data};
                    else
                        frame <= {1'b1, 1'b1, 1'b1, tx_par, tx_data[6:0]};
                end else begin
                    tx_state <= TX_IDLE;
                    tx_line  <= 1'b1;
                end
            end
        end
    end

    // hardware set wins over the data write
    always_ff @(posedge clock_i) begin
        if (reset_i || !cfg.unit_on) begin
            tx_buf_empty <= 1'b1;
            tx_done      <= 1'b1;
        end else begin
            if (load_data)
                tx_buf_empty <= 1'b1;
            else if (write_i && addr_i == DATA_BUF_ADDR)
                tx_buf_empty <= 1'b0;
            tx_done <= tx_buf_empty && tx_state == TX_IDLE && !pre_pend
                       && !brk_go && !brk_tail;
        end
    end

    // registered pin, inversion covers idle and break too
    always_ff @(posedge clock_i) begin
        if (reset_i)
            txd_o <= 1'b1;
        else
            txd_o <= tx_line ^ cfg.tx_polarity_flip;
    end

    // interrupt requests
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_irq_o  <= 1'b0;
            rx_irq_o  <= 1'b0;
            err_irq_o <= 1'b0;
        end else begin
            tx_irq_o  <= cfg.unit_on && ((tx_empty_irq_en && tx_buf_empty)
                         || (tx_done_irq_en && tx_done));
            rx_irq_o  <= !rx_standby && ((rx_full_irq_en && rx_buf_full)
                         || (idle_irq_en && idle_flag));
            err_irq_o <= |(err_irq_en & {overrun, noise_flag, framing_bad, parity_bad});
        end
    end

endmodule // asc_top

//--- asc_top_sva.sv
module asc_top_sva import asc_pkg::*; #(
    parameter int BAUD_DIV = 4
) (
    input wire logic       clock_i,
    input wire logic       reset_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       write_i,
    input wire logic       read_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rxd_i,
    input wire logic       txd_o,
    input wire logic       tx_irq_o,
    input wire logic       rx_irq_o,
    input wire logic       err_irq_o
);
    logic [7:0] one_q, two_q, three_q;
    // standby clears itself, so only written enables are trusted
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            one_q   <= 8'h00;
            two_q   <= 8'h00;
            three_q <= 8'h00;
        end else if (write_i) begin
            if (addr_i == CTRL_ONE_ADDR) one_q <= wdata_i;
            if (addr_i == CTRL_TWO_ADDR) two_q <= wdata_i;
            if (addr_i == CTRL_THREE_ADDR) three_q <= wdata_i;
        end
    end
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (reset_i);
    one_back_a: assert property (write_i && addr_i == CTRL_ONE_ADDR ##1 !write_i
        ##1 read_i && addr_i == CTRL_ONE_ADDR |=> rdata_o == ($past(wdata_i, 3) & 8'h7F))
        else $error("ctrl_one readback wrong");
    two_refuse_a: assert property (write_i && addr_i == CTRL_TWO_ADDR && !one_q[6]
        ##1 !write_i ##1 read_i && addr_i == CTRL_TWO_ADDR |=> rdata_o[3:2] == 2'b00)
        else $error("enable written while unit off");
    off_idle_a: assert property (!one_q[6] [*3] |-> txd_o == !one_q[5])
        else $error("idle level wrong");
    off_mask_a: assert property (!one_q[6] [*3] |-> !tx_irq_o)
        else $error("tx irq while unit off");
    tx_gate_a: assert property (two_q[7:6] == 2'b00 [*3] |-> !tx_irq_o)
        else $error("tx irq not enabled");
    rx_gate_a: assert property (two_q[5:4] == 2'b00 [*3] |-> !rx_irq_o)
        else $error("rx irq not enabled");
    err_gate_a: assert property (three_q[3:0] == 4'h0 [*3] |-> !err_irq_o)
        else $error("err irq not enabled");
    preamble_idle_a: assert property ($rose(two_q[3]) && one_q[6] && !two_q[0]
        |-> (txd_o == !one_q[5]) [*8])
        else $error("preamble not idle");
    cover property ($rose(tx_irq_o));
    cover property ($rose(rx_irq_o));
    cover property ($rose(err_irq_o));
endmodule // asc_top_sva

bind asc_top asc_top_sva #(.BAUD_DIV(BAUD_DIV)) sva_i (.clock_i(clock_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .tx_irq_o(tx_irq_o),
    .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));

//--- asc_remote.sv
module asc_remote (
    input  wire logic clock_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CLKS = 16;
    // line pulled high between frames
    initial rxd_o = 1'b1;
    task automatic send(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxd_o <= bits[i];
            repeat (BIT_CLKS) @(posedge clock_i);
        end
        rxd_o <= 1'b1;
    endtask
    // bounded hunt for a start edge, then mid-bit samples
    task automatic grab(input logic flip, input int n, output logic [10:0] bits,
        output int waited);
        bits = '0;
        waited = 0;
        while ((txd_i ^ flip) !== 1'b0 && waited < 2000) begin
            @(posedge clock_i);
            waited++;
        end
        repeat (BIT_CLKS / 2) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            bits[i] = txd_i ^ flip;
            repeat (BIT_CLKS) @(posedge clock_i);
        end
    endtask
endmodule // asc_remote

//--- asc_bench.sv
module asc_bench import asc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        write_i = 1'b0;
    logic        read_i  = 1'b0;
    logic [2:0]  addr_i  = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  rdata_o, got;
    logic        rxd_i, txd_o, tx_irq_o, rx_irq_o, err_irq_o;
    logic [10:0] bits;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          waited, nb, ev;
    always #5 clock_i = ~clock_i;
    asc_top #(.BAUD_DIV(1)) DUT (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .rxd_i(rxd_i), .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
        .err_irq_o(err_irq_o));
    asc_remote far (.clock_i(clock_i), .txd_i(txd_o), .rxd_o(rxd_i));
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // strobe dropped one edge early so tasks may follow each other
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        write_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        write_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        read_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge clock_i);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        logic [8:0] ch;
        logic [7:0] cfg;
        void'($urandom(32'h6b2e));
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        wr(3'h7, 8'hFF);
        wr(CTRL_TWO_ADDR, 8'h0C);
        for (int a = 0; a < 8; a++) begin
            if (a != 4) begin
                rd(3'(a), got);
                check("reset read", (a == 3) ? 11'h0C0 : {3'h0, CTRL_RESET}, {3'h0, got});
            end
        end
        for (int c = 0; c < 4; c++) begin
            cfg = {2'b01, c == 3, c[0], 2'b00, c[1], 1'($urandom)};
            ch = 9'($urandom);
            nb = c[0] ? 9 : 8;
            wr(CTRL_ONE_ADDR, cfg);
            wr(CTRL_THREE_ADDR, {1'b0, ch[8], 6'h0F});
            wr(CTRL_TWO_ADDR, 8'h08);
            wr(DATA_BUF_ADDR, ch[7:0]);
            far.grab(cfg[5], nb + 2, bits, waited);
            check("preamble", 11'(waited >= nb * 16 + 28 && waited <= nb * 16 + 60), 11'h001);
            ev = c[0] ? int'(ch) : int'(ch[7:0]);
            if (c[1]) begin
                ev = ev & ((1 << (nb - 1)) - 1);
                ev = ev | ((($countones(ev) + cfg[0]) & 1) << (nb - 1));
            end
            ev = (ev << 1) | (1 << (nb + 1));
            check("frame", 11'(ev), bits);
            wr(CTRL_TWO_ADDR, 8'h00);
        end
        ch = 9'($urandom);
        wr(CTRL_ONE_ADDR, 8'h40);
        wr(CTRL_TWO_ADDR, 8'hA4);
        far.send({2'b11, ch[7:0], 1'b0}, 10);
        repeat (6) @(posedge clock_i);
        check("irq", {9'h0, tx_irq_o, rx_irq_o}, 11'h003);
        rd(STAT_ONE_ADDR, got);
        check("rx full", {10'h0, got[5]}, 11'h001);
        rd(DATA_BUF_ADDR, got);
        check("rx data", {3'h0, got}, {3'h0, ch[7:0]});
        rd(CTRL_THREE_ADDR, got);
        check("rx ninth", {10'h0, got[7]}, {10'h0, ch[7]});
        wr(CTRL_THREE_ADDR, 8'h02);
        far.send({3'b000, ch[7:0], 1'b0}, 10);
        repeat (6) @(posedge clock_i);
        check("err irq", {10'h0, err_irq_o}, 11'h001);
        wr(CTRL_TWO_ADDR, 8'h09);
        wr(CTRL_TWO_ADDR, 8'h08);
        far.grab(1'b0, 11, bits, waited);
        check("break", bits, 11'h400);
        summarize();
    end
    initial begin
        #400_000;
        n_mismatch++;
        summarize();
    end
endmodule // asc_bench
